// [core/tabc_timer16.sv]
`timescale 1ns/1ps
`include "tabc_defines.svh"

module tabc_timer16 import tabc_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic stop_i,
  input wire logic wr_i,
  input wire logic latch_only_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] count_o,
  output logic [15:0] reload_o,
  output logic uf_o,
  output logic step_o
);

  // =====================================================================
  // Parameter check.
  if (CNT_W != 16) begin : g_bad_width
    $error("tabc_timer16 supports only a 16-bit count");
  end

  tmr_state_t s_q;
  tmr_state_t s_d;

  // =====================================================================
  // Down-counter with reload latch.
  always_comb begin
    s_d = s_q;
    s_d.uf = 1'b0;
    s_d.step = 1'b0;
    if (tick_i && !stop_i) begin
      s_d.step = 1'b1;
      if (s_q.count == 16'h0000) begin
        s_d.count = s_q.reload;
        s_d.uf = 1'b1;
      end else begin
        s_d.count = s_q.count - 16'h0001;
      end
    end
    if (wr_i) begin
      s_d.reload = wdata_i;
      if (!latch_only_i) begin
        s_d.count = wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{count: `TMR_RST_VAL, reload: `TMR_RST_VAL, uf: 1'b0, step: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;
  assign reload_o = s_q.reload;
  assign uf_o = s_q.uf;
  assign step_o = s_q.step;

  // =====================================================================
  // Checks.
  a_uf_reload: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (tick_i && !stop_i && !wr_i && s_q.count == 16'h0000) |=> (uf_o && count_o == $past(s_q.reload)))
    else $error("underflow did not reload the counter");
  a_count_down: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (tick_i && !stop_i && !wr_i && s_q.count != 16'h0000) |=> (!uf_o && count_o == $past(s_q.count) - 16'h0001))
    else $error("counter did not decrement by one");
  a_latch_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && latch_only_i && (stop_i || !tick_i)) |=> (reload_o == $past(wdata_i) && $stable(count_o)))
    else $error("latch-only write touched the counter");
  a_latch_and_cnt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && !latch_only_i) |=> (count_o == $past(wdata_i) && reload_o == $past(wdata_i)))
    else $error("write did not load latch and counter");

endmodule // tabc_timer16

// [core/timer_ab_output_compare.sv]
// Function
// - Timers are 16-bit down-counters reloading after zero.
// - Each underflow raises that timer's request flag.
// - Reload value n divides count clock by n+1.
// - Selectable prescaled or ring/underflow count sources.
// - Write-control bit picks latch or latch-and-counter.
// - Latch-only writes never touch the counter.
// - Timer reads return the live count.
// - Four channels, each on timer A or B.
// - Pending reload transfers at source timer underflow.
// - Stopped source timer loads compare latch immediately.
// - Match on equal count; never above reload.
// - Trigger enable gates output changes.
// - Polarity bit sets x0 and x1 levels.
// - Output levels readable in status register.
// - Enabled latch matches raise shared compare request.
// - Matches still signal with trigger disabled.
// - Pair modulation outputs AND of paired channels.
`timescale 1ns/1ps
`include "tabc_defines.svh"

module timer_ab_output_compare import tabc_pkg::*; #(
  parameter int N_CH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic ring_osc_i,
  output logic [7:0] rdata_o,
  output logic [3:0] cmp_pin_o,
  output logic [3:0] cmp_pin_oe_o,
  output logic ta_irq_o,
  output logic tb_irq_o,
  output logic cmp_irq_o
);

  // =====================================================================
  // Parameter check.
  if (N_CH != 4) begin : g_bad_ch
    $error("the compare unit is built for exactly four channels");
  end

  cmp_state_t s_q;
  cmp_state_t s_d;

  logic [15:0] ta_cnt;
  logic [15:0] tb_cnt;
  logic [15:0] ta_rel;
  logic [15:0] tb_rel;
  logic ta_uf;
  logic tb_uf;
  logic ta_step;
  logic tb_step;
  logic ta_tick;
  logic tb_tick;
  logic ta_wr;
  logic tb_wr;
  logic ring_edge;
  logic [7:0] ta_hi_w;
  logic pair_and_w;
  logic [3:0][1:0] match_w;
  logic [3:0] src_uf_w;
  logic [3:0] src_stop_w;

  // =====================================================================
  // Count sources.
  function automatic logic tick_sel(input logic [2:0] src, input logic [7:0] pre, input logic alt);
    case (src)
      `SRC_DIV2: tick_sel = pre[0];
      `SRC_DIV16: tick_sel = &pre[3:0];
      `SRC_DIV32: tick_sel = &pre[4:0];
      `SRC_DIV64: tick_sel = &pre[5:0];
      `SRC_DIV128: tick_sel = &pre[6:0];
      `SRC_DIV256: tick_sel = &pre;
      `SRC_ALT: tick_sel = alt;
      default: tick_sel = 1'b0;
    endcase
  endfunction

  // The ring clock is slow and asynchronous, so it is counted by its synchronised rising edge.
  assign ring_edge = s_q.ring_sync[1] & ~s_q.ring_sync[2];
  assign ta_tick = tick_sel(s_q.ta_ctl.src, s_q.pre, ring_edge);
  assign tb_tick = tick_sel(s_q.tb_ctl.src, s_q.pre, ta_uf);
  assign ta_wr = wr_i && (addr_i == `REG_TA_HI);
  assign tb_wr = wr_i && (addr_i == `REG_TB_HI);
  assign ta_hi_w = ta_cnt[15:8];
  assign pair_and_w = s_q.lvl[0] & s_q.lvl[1];

  // =====================================================================
  // Timers.
  tabc_timer16 #(.CNT_W(16)) u_timer_a (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(ta_tick),
    .stop_i(s_q.ta_ctl.stop),
    .wr_i(ta_wr),
    .latch_only_i(s_q.ta_ctl.latch_only),
    .wdata_i({wdata_i, s_q.wbuf}),
    .count_o(ta_cnt),
    .reload_o(ta_rel),
    .uf_o(ta_uf),
    .step_o(ta_step)
  );

  tabc_timer16 #(.CNT_W(16)) u_timer_b (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tb_tick),
    .stop_i(s_q.tb_ctl.stop),
    .wr_i(tb_wr),
    .latch_only_i(s_q.tb_ctl.latch_only),
    .wdata_i({wdata_i, s_q.wbuf}),
    .count_o(tb_cnt),
    .reload_o(tb_rel),
    .uf_o(tb_uf),
    .step_o(tb_step)
  );

  // =====================================================================
  // Per-channel time base and match detection.
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    logic [15:0] cnt_w;
    logic [15:0] rel_w;
    logic step_w;
    assign cnt_w = s_q.tsrc[ch] ? tb_cnt : ta_cnt;
    assign rel_w = s_q.tsrc[ch] ? tb_rel : ta_rel;
    assign step_w = s_q.tsrc[ch] ? tb_step : ta_step;
    assign src_uf_w[ch] = s_q.tsrc[ch] ? tb_uf : ta_uf;
    assign src_stop_w[ch] = s_q.tsrc[ch] ? s_q.tb_ctl.stop : s_q.ta_ctl.stop;
    for (genvar k = 0; k < 2; k++) begin : g_lat
      // The count only reaches a latch value not above the reload value.
      assign match_w[ch][k] = step_w && (cnt_w == s_q.cmp_lat[ch][k]) && (s_q.cmp_lat[ch][k] <= rel_w);

      a_no_high_match: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (s_q.cmp_lat[ch][k] > rel_w) |-> !match_w[ch][k])
        else $error("match reported for a latch above the reload value");
      a_stop_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (s_q.reload_pend[2*ch+k] && src_stop_w[ch]) |=> (s_q.cmp_lat[ch][k] == $past(s_q.cmp_reg[ch])))
        else $error("stopped source timer did not load the latch at once");
      // A pending latch reload lands one cycle after the source timer's underflow flag is set.
      a_uf_transfer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (s_q.reload_pend[2*ch+k] && src_uf_w[ch]) |=> (s_q.cmp_lat[ch][k] == $past(s_q.cmp_reg[ch])))
        else $error("pending reload did not transfer at source underflow");
    end

    a_trig_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !s_q.trig_en[ch] |=> $stable(s_q.lvl[ch]))
      else $error("output level moved with trigger disabled");
    a_pol_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.trig_en[ch] && match_w[ch][0] && !match_w[ch][1]) |=> (s_q.lvl[ch] == !$past(s_q.pol[ch])))
      else $error("x0 match gave the wrong output level");
  end

  // =====================================================================
  // Next state.
  always_comb begin
    s_d = s_q;
    s_d.ta_irq = ta_uf;
    s_d.tb_irq = tb_uf;
    s_d.cmp_irq = |(match_w & s_q.irq_src);
    s_d.rdata = `RST_BYTE;
    s_d.pre = s_q.pre + 8'h01;
    s_d.ring_sync = {s_q.ring_sync[1:0], ring_osc_i};

    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 2; k++) begin
        if (s_q.reload_pend[2*ch+k] && (src_uf_w[ch] || src_stop_w[ch])) begin
          s_d.cmp_lat[ch][k] = s_q.cmp_reg[ch];
          s_d.reload_pend[2*ch+k] = 1'b0;
        end
      end
      if (s_q.trig_en[ch]) begin
        if (match_w[ch][0]) begin
          s_d.lvl[ch] = ~s_q.pol[ch];
        end
        // Equal latches are not allowed; should both match, x1 decides.
        if (match_w[ch][1]) begin
          s_d.lvl[ch] = s_q.pol[ch];
        end
      end
    end

    s_d.pin[0] = s_q.port_en[0] & (s_q.mod[0] ? pair_and_w : s_q.lvl[0]);
    s_d.pin[1] = s_q.port_en[1] & s_q.lvl[1];
    s_d.pin[2] = s_q.port_en[2] & (s_q.mod[1] ? (s_q.lvl[2] & s_q.lvl[3]) : s_q.lvl[2]);
    s_d.pin[3] = s_q.port_en[3] & s_q.lvl[3];

    if (wr_i) begin
      if (addr_i == `REG_TA_LO || addr_i == `REG_TB_LO || addr_i == `REG_CMP_LO) begin
        s_d.wbuf = wdata_i;
      end else if (addr_i == `REG_MODE) begin
        s_d.ta_ctl.latch_only = wdata_i[`MODE_A_LATCH_ONLY];
        s_d.tb_ctl.latch_only = wdata_i[`MODE_B_LATCH_ONLY];
        s_d.ta_ctl.stop = wdata_i[`MODE_A_STOP];
        s_d.tb_ctl.stop = wdata_i[`MODE_B_STOP];
      end else if (addr_i == `REG_CSS) begin
        s_d.ta_ctl.src = wdata_i[2:0];
        s_d.tb_ctl.src = wdata_i[5:3];
      end else if (addr_i == `REG_WPTR) begin
        s_d.wptr = wdata_i[1:0];
      end else if (addr_i == `REG_CMP_HI) begin
        s_d.cmp_reg[s_q.wptr] = {wdata_i, s_q.wbuf};
      end else if (addr_i == `REG_RELOAD) begin
        s_d.reload_pend = s_d.reload_pend | wdata_i;
      end else if (addr_i == `REG_TRIG) begin
        s_d.trig_en = wdata_i[3:0];
        s_d.pol = wdata_i[7:4];
      end else if (addr_i == `REG_PORT) begin
        s_d.port_en = wdata_i[3:0];
        s_d.mod = wdata_i[5:4];
      end else if (addr_i == `REG_TSRC) begin
        s_d.tsrc = wdata_i[3:0];
      end else if (addr_i == `REG_IRQSRC) begin
        s_d.irq_src = wdata_i;
      end
    end

    if (rd_i) begin
      if (addr_i == `REG_TA_HI) begin
        s_d.rdata = ta_cnt[15:8];
        s_d.rbuf = ta_cnt[7:0];
      end else if (addr_i == `REG_TB_HI) begin
        s_d.rdata = tb_cnt[15:8];
        s_d.rbuf = tb_cnt[7:0];
      end else if (addr_i == `REG_TA_LO || addr_i == `REG_TB_LO) begin
        s_d.rdata = s_q.rbuf;
      end else if (addr_i == `REG_MODE) begin
        s_d.rdata = {4'h0, s_q.tb_ctl.stop, s_q.ta_ctl.stop, s_q.tb_ctl.latch_only, s_q.ta_ctl.latch_only};
      end else if (addr_i == `REG_CSS) begin
        s_d.rdata = {2'h0, s_q.tb_ctl.src, s_q.ta_ctl.src};
      end else if (addr_i == `REG_WPTR) begin
        s_d.rdata = {6'h00, s_q.wptr};
      end else if (addr_i == `REG_RELOAD) begin
        s_d.rdata = s_q.reload_pend;
      end else if (addr_i == `REG_TRIG) begin
        s_d.rdata = {s_q.pol, s_q.trig_en};
      end else if (addr_i == `REG_PORT) begin
        s_d.rdata = {2'h0, s_q.mod, s_q.port_en};
      end else if (addr_i == `REG_TSRC) begin
        s_d.rdata = {4'h0, s_q.tsrc};
      end else if (addr_i == `REG_STATUS) begin
        s_d.rdata = {4'h0, s_q.lvl};
      end else if (addr_i == `REG_IRQSRC) begin
        s_d.rdata = s_q.irq_src;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Outputs.
  assign rdata_o = s_q.rdata;
  assign cmp_pin_o = s_q.pin;
  assign cmp_pin_oe_o = s_q.port_en;
  assign ta_irq_o = s_q.ta_irq;
  assign tb_irq_o = s_q.tb_irq;
  assign cmp_irq_o = s_q.cmp_irq;

  // =====================================================================
  // Checks.
  a_ta_irq_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ta_uf |=> ta_irq_o)
    else $error("timer A underflow did not raise its request");
  a_tb_irq_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tb_uf |=> tb_irq_o)
    else $error("timer B underflow did not raise its request");
  a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `REG_STATUS) |=> (rdata_o == {4'h0, $past(s_q.lvl)}))
    else $error("status read did not return the output levels");
  a_ring_tick: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.ta_ctl.src == `SRC_ALT && !s_q.ta_ctl.stop && ring_edge) |=> ta_step)
    else $error("ring clock edge did not step timer A");
  a_read_live: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `REG_TA_HI) |=> (rdata_o == $past(ta_hi_w)))
    else $error("timer A high read did not return the live count");
  a_cmp_irq_raise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (|(match_w & s_q.irq_src)) |=> cmp_irq_o)
    else $error("enabled match did not raise the compare request");
  a_pair_and: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.mod[0] && s_q.port_en[0]) |=> (cmp_pin_o[0] == $past(pair_and_w)))
    else $error("pair pin is not the AND of channels 0 and 1");

  c_ta_uf: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) ta_uf ##1 ta_irq_o);
  c_cmp_irq: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) cmp_irq_o);
  c_pair_high: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) s_q.mod[0] && cmp_pin_o[0]);
  c_trig_off: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) !s_q.trig_en[0] && cmp_irq_o);
  c_ring_step: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) s_q.ta_ctl.src == `SRC_ALT && ta_step);

endmodule // timer_ab_output_compare

// [dv/test_timer_ab_output_compare.sv]
`timescale 1ns/1ps
`include "tabc_defines.svh"

module test_timer_ab_output_compare;
  import tabc_pkg::*;

  // ==========================================================
  // Clock, reset and stimulus signals.
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ring_osc_i = 1'b0;
  logic [7:0] rdata_o;
  logic [3:0] cmp_pin_o;
  logic [3:0] cmp_pin_oe_o;
  logic ta_irq_o;
  logic tb_irq_o;
  logic cmp_irq_o;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int na;
  int per;
  int hi;
  int irq;

  timer_ab_output_compare uut (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .ring_osc_i(ring_osc_i),
    .rdata_o(rdata_o),
    .cmp_pin_o(cmp_pin_o),
    .cmp_pin_oe_o(cmp_pin_oe_o),
    .ta_irq_o(ta_irq_o),
    .tb_irq_o(tb_irq_o),
    .cmp_irq_o(cmp_irq_o)
  );

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // The ring oscillator runs free, slower than and unrelated to the system clock.
  initial begin
    forever #37.3 ring_osc_i = ~ring_osc_i;
  end

  // ==========================================================
  // Comparison, bus tasks and closing.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask

  // Loads a 16-bit timer value, low byte first.
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 4'h1, v[15:8]);
  endtask

  // Programs latch k of channel c through the write pointer.
  task automatic setcmp(input int c, input int k, input logic [15:0] v);
    wr(`REG_WPTR, 8'(c));
    wr16(`REG_CMP_LO, v);
    wr(`REG_RELOAD, 8'(1 << (2 * c + k)));
  endtask

  // Returns the spacing in cycles of the second and third pulses on timer A or B requests.
  // The first pulse is skipped, since it may still belong to the previous count source.
  task automatic period(input bit use_b, output int cyc);
    int n;
    time t0;
    cyc = -1;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin
        @(negedge sys_clk_i);
        n++;
      end while (((use_b ? tb_irq_o : ta_irq_o) !== 1'b1) && n < 5000);
      if (p == 1) begin
        t0 = $time;
      end else if (p == 2) begin
        cyc = int'(($time - t0) / 10);
      end
    end
  endtask

  // Counts pin 0 high cycles and compare requests over ten periods of 16 cycles.
  task automatic win(output int h, output int q);
    h = 0;
    q = 0;
    repeat (20) @(posedge sys_clk_i);
    repeat (160) begin
      @(negedge sys_clk_i);
      h += (cmp_pin_o[0] === 1'b1);
      q += (cmp_irq_o === 1'b1);
    end
  endtask

  // ==========================================================
  // Read data monitor: each answer is taken against the oldest note.
  always @(posedge sys_clk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        chk(16'hDEAD, 16'h0000);
      end else begin
        chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
      end
    end
    rd_seen <= rd_i;
  end

  initial begin
    #300000;
    n_fail++;
    end_sim();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hBECC));
    na = 3 + $urandom_range(3);
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`REG_TA_HI, 8'hFF);
    rd(`REG_TA_LO, 8'hFF);
    rd(`REG_MODE, 8'h00);
    rd(`REG_STATUS, 8'h00);
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00);
    wr(`REG_MODE, 8'h04);
    wr16(`REG_TA_LO, 16'h1234);
    rd(`REG_TA_HI, 8'h12);
    rd(`REG_TA_LO, 8'h34);
    wr(`REG_MODE, 8'h05);
    wr16(`REG_TA_LO, 16'h5678);
    rd(`REG_TA_HI, 8'h12);
    rd(`REG_TA_LO, 8'h34);
    wr(`REG_MODE, 8'h04);
    wr16(`REG_TA_LO, 16'(na));
    wr(`REG_MODE, 8'h00);
    period(1'b0, per);
    chk(16'(per), 16'((na + 1) * 2));
    for (int s = 1; s < 6; s++) begin
      wr(`REG_CSS, 8'(s));
      period(1'b0, per);
      chk(16'(per), 16'((na + 1) * (8 << s)));
    end
    wr(`REG_MODE, 8'h08);
    wr16(`REG_TB_LO, 16'h0002);
    rd(`REG_TB_HI, 8'h00);
    rd(`REG_TB_LO, 8'h02);
    wr(`REG_CSS, {2'b00, `SRC_ALT, `SRC_DIV2});
    wr(`REG_MODE, 8'h00);
    period(1'b1, per);
    chk(16'(per), 16'(3 * (na + 1) * 2));
    wr(`REG_MODE, 8'h04);
    wr(`REG_CSS, {2'b00, `SRC_ALT, `SRC_ALT});
    wr16(`REG_TA_LO, 16'h0003);
    wr(`REG_MODE, 8'h00);
    period(1'b0, per);
    chk(16'(per >= 29 && per <= 31), 16'h0001);
    wr(`REG_MODE, 8'h04);
    wr(`REG_CSS, {2'b00, `SRC_ALT, `SRC_DIV2});
    wr16(`REG_TA_LO, 16'h0007);
    setcmp(0, 0, 16'h0002);
    setcmp(0, 1, 16'h0005);
    wr(`REG_IRQSRC, 8'h03);
    wr(`REG_PORT, 8'h01);
    wr(`REG_TRIG, 8'h01);
    wr(`REG_MODE, 8'h00);
    repeat (14) @(posedge sys_clk_i);
    wr(`REG_MODE, 8'h04);
    rd(`REG_STATUS, 8'h01);
    @(negedge sys_clk_i);
    chk(16'(cmp_pin_oe_o), 16'h0001);
    wr(`REG_MODE, 8'h00);
    win(hi, irq);
    chk(16'(hi), 16'd100);
    chk(16'(irq), 16'd20);
    wr(`REG_TRIG, 8'h11);
    win(hi, irq);
    chk(16'(hi), 16'd60);
    wr(`REG_TRIG, 8'h10);
    win(hi, irq);
    chk(16'(hi == 0 || hi == 160), 16'h0001);
    chk(16'(irq), 16'd20);
    wr(`REG_TRIG, 8'h01);
    setcmp(0, 1, 16'h0009);
    win(hi, irq);
    rd(`REG_RELOAD, 8'h00);
    chk(16'(irq), 16'd10);
    chk(16'(hi), 16'd160);
    wr(`REG_MODE, 8'h04);
    setcmp(0, 1, 16'h0005);
    setcmp(1, 0, 16'h0006);
    setcmp(1, 1, 16'h0002);
    wr(`REG_TRIG, 8'h03);
    wr(`REG_PORT, 8'h11);
    wr(`REG_MODE, 8'h00);
    win(hi, irq);
    chk(16'(hi), 16'd20);
    repeat (4) @(posedge sys_clk_i);
    end_sim();
  end
endmodule // test_timer_ab_output_compare

// [inc/tabc_defines.svh]
`ifndef TABC_DEFINES_SVH
`define TABC_DEFINES_SVH

// =====================================================================
// Register offsets.
`define REG_TA_LO 4'h0
`define REG_TA_HI 4'h1
`define REG_TB_LO 4'h2
`define REG_TB_HI 4'h3
`define REG_MODE 4'h4
`define REG_CSS 4'h5
`define REG_WPTR 4'h6
`define REG_CMP_LO 4'h7
`define REG_CMP_HI 4'h8
`define REG_RELOAD 4'h9
`define REG_TRIG 4'hA
`define REG_PORT 4'hB
`define REG_TSRC 4'hC
`define REG_STATUS 4'hD
`define REG_IRQSRC 4'hE

// =====================================================================
// Field positions of the timer mode register.
`define MODE_A_LATCH_ONLY 0
`define MODE_B_LATCH_ONLY 1
`define MODE_A_STOP 2
`define MODE_B_STOP 3

// =====================================================================
// Count source codes.
`define SRC_DIV2 3'h0
`define SRC_DIV16 3'h1
`define SRC_DIV32 3'h2
`define SRC_DIV64 3'h3
`define SRC_DIV128 3'h4
`define SRC_DIV256 3'h5
`define SRC_ALT 3'h6

// =====================================================================
// Reset values.
`define TMR_RST_VAL 16'hFFFF
`define RST_BYTE 8'h00

`endif

// [inc/tabc_pkg.sv]
package tabc_pkg;

  typedef struct packed {
    logic latch_only;
    logic stop;
    logic [2:0] src;
  } tmr_ctrl_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic uf;
    logic step;
  } tmr_state_t;

  typedef struct packed {
    logic [7:0] pre;
    logic [2:0] ring_sync;
    logic [7:0] wbuf;
    logic [7:0] rbuf;
    logic [7:0] rdata;
    tmr_ctrl_t ta_ctl;
    tmr_ctrl_t tb_ctl;
    logic [1:0] wptr;
    logic [3:0][15:0] cmp_reg;
    logic [3:0][1:0][15:0] cmp_lat;
    logic [7:0] reload_pend;
    logic [7:0] irq_src;
    logic [3:0] trig_en;
    logic [3:0] pol;
    logic [3:0] port_en;
    logic [3:0] tsrc;
    logic [3:0] lvl;
    logic [3:0] pin;
    logic [1:0] mod;
    logic ta_irq;
    logic tb_irq;
    logic cmp_irq;
  } cmp_state_t;

endpackage
